/* File: pkg/erc_pkg.sv */
`default_nettype none
package erc_pkg;
  // timing
  localparam int CLK_PERIOD_NS    = 40;
  localparam int RST_LOW_MIN_NS   = 400;
  localparam int RST_LOW_CYCLES   = (RST_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHY_RST_DELAY_NS = 100000;
  localparam int PHY_RST_CYCLES   = (PHY_RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRC_HOLD_NS      = 1000;
  localparam int SRC_HOLD_CYCLES  = (SRC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // serial command opcodes (upper three bits of the first byte)
  localparam logic [2:0] OP_READ  = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_BSET  = 3'h4;
  localparam logic [2:0] OP_BCLR  = 3'h5;
  localparam logic [2:0] OP_SYSRST = 3'h7;

  // register addresses (lower five bits of the first byte)
  localparam logic [4:0] ADDR_PHY_CTRL_LO = 5'h10;
  localparam logic [4:0] ADDR_PHY_CTRL_HI = 5'h11;
  localparam logic [4:0] ADDR_ETH_CTRL    = 5'h1f;

  // ethernet_control_one fields
  localparam int ECTL_TX_RST  = 7;
  localparam int ECTL_RX_RST  = 6;
  localparam int ECTL_TX_REQ  = 3;
  localparam int ECTL_RX_EN   = 2;
  localparam logic [7:0] ECTL_RESET = 8'h00;

  // phy_control_one fields
  localparam int PCTL_SOFT_RST   = 15;
  localparam int PCTL_LOOPBACK   = 14;
  localparam int PCTL_POWER_DOWN = 11;
  localparam int PCTL_DUPLEX     = 8;
  localparam logic [15:0] PCTL_RESET      = 16'h0000;
  localparam logic [15:0] PCTL_STORE_MASK = 16'h4d80;

  typedef struct packed {
    logic sys;
    logic tx;
    logic rx;
    logic phy;
  } erc_resets_s;

  typedef struct packed {
    logic loopback;
    logic powerDown;
    logic fullDuplex;
  } erc_phy_mode_s;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_DATA,
    PH_DONE
  } erc_phase_e;
endpackage : erc_pkg
`default_nettype wire

/* File: rtl/erc_reset_filter.sv */
`default_nettype none
module erc_reset_filter (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // pin side
  input  wire logic resetPinN,
  // filtered level
  output logic      pinResetQ
);
  localparam int CW = $clog2(erc_pkg::RST_LOW_CYCLES + 1) + 1;
  localparam logic [CW-1:0] LIMIT = CW'(erc_pkg::RST_LOW_CYCLES);

  logic [CW-1:0] lowCnt_q;

  // count low cycles, saturating at the limit
  always_ff @(posedge ref_clk) begin
    if (rst || resetPinN) begin
      lowCnt_q <= '0;
    end else if (lowCnt_q != LIMIT) begin
      lowCnt_q <= lowCnt_q + CW'(1);
    end
  end

  // glitch filter
  // a low run of LIMIT cycles or fewer never reaches here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinResetQ <= 1'b0;
    end else begin
      pinResetQ <= !resetPinN && (lowCnt_q == LIMIT);
    end
  end
endmodule : erc_reset_filter
`default_nettype wire

/* File: rtl/erc_phy_reset_timer.sv */
`default_nettype none
module erc_phy_reset_timer (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  // status
  output logic      busyQ
);
  localparam int CW = $clog2(erc_pkg::PHY_RST_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(erc_pkg::PHY_RST_CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // self clearing delay
  // a new start while busy is ignored, so the host cannot shorten it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busyQ <= 1'b0;
      cnt_q <= '0;
    end else if (!busyQ && start) begin
      busyQ <= 1'b1;
      cnt_q <= LOAD;
    end else if (busyQ) begin
      if (cnt_q == '0) begin
        busyQ <= 1'b0;
      end else begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end
endmodule : erc_phy_reset_timer
`default_nettype wire

/* File: rtl/erc_reset_control.sv */
// Summary of operation
// - power-on reset loads every register default; packet buffer left undefined
// - system reset while reset pin low or on serial reset command
// - low pulses up to the minimum width on the pin are ignored
// - internal resets never drive the external reset pin low
// - system reset restores registers, keeps packet buffer contents
// - system reset includes transmit-only and receive-only resets
// - writing 1 to transmit reset bit resets transmit logic only
// - transmit reset aborts a frame in flight and clears transmit request
// - transmit-only reset leaves other registers and blocks alone
// - writing 1 to receive reset bit resets receive logic only
// - receive reset clears receive enable and aborts frame being received
// - receive-only reset leaves other registers and blocks alone
// - bit 15 of PHY control resets PHY and its registers
// - PHY reset bit holds for a delay then clears itself
// - bit 14 loops transmit data back and disables twisted pair
// - bit 11 shuts the PHY down
// - bit 8 selects full duplex when 1, half when 0
// - host sets transmit request; device clears it on finish or abort
`default_nettype none
module erc_reset_control (
  // clock and power-on reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // external reset pin, input only
  input  wire logic                   resetPinN,
  // serial host port
  input  wire logic                   spiCsN,
  input  wire logic                   spiSck,
  input  wire logic                   spiMosi,
  output logic                        spiMiso,
  output logic                        spiMisoOe,
  // transmit engine
  input  wire logic                   txFrameDone,
  output logic                        txRequest,
  // receive engine
  output logic                        rxEnable,
  // reset fan-out
  output erc_pkg::erc_resets_s        resets,
  // PHY controls
  output erc_pkg::erc_phy_mode_s      phyMode
);

  // reset sources
  logic                   pinResetQ;
  logic                   srcPulse;
  logic                   srcActive_q;
  logic [7:0]             srcCnt_q;
  logic                   sysReset;
  logic                   regRst;

  // serial engine
  logic                   sckPrev_q;
  logic                   sckRise;
  logic                   sckFall;
  erc_pkg::erc_phase_e    phase_q;
  logic [2:0]             bitCnt_q;
  logic [7:0]             inShift_q;
  logic [7:0]             outShift_q;
  logic [2:0]             opcode_q;
  logic [4:0]             addr_q;
  logic [7:0]             byteIn;
  logic                   byteDone;
  logic                   wrStrobe;
  logic [7:0]             wrData;

  // registers
  logic [7:0]             ethCtrl_q;
  logic [15:0]            phyCtrl_q;
  logic                   phyBusy;
  logic                   phyStart;
  logic [7:0]             rdData;
  logic [7:0]             ethNew;
  logic [15:0]            phyNew;

  erc_reset_filter u_filter (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .resetPinN (resetPinN),
    .pinResetQ (pinResetQ)
  );

  // ---------------------------------------------------------------
  // system reset
  // ---------------------------------------------------------------

  // serial reset command
  // the command is stretched so every path sees a full reset window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      srcActive_q <= 1'b0;
      srcCnt_q    <= 8'h00;
    end else if (srcPulse) begin
      srcActive_q <= 1'b1;
      srcCnt_q    <= 8'(erc_pkg::SRC_HOLD_CYCLES - 1);
    end else if (srcActive_q) begin
      if (srcCnt_q == 8'h00) begin
        srcActive_q <= 1'b0;
      end else begin
        srcCnt_q <= srcCnt_q - 8'h01;
      end
    end
  end

  assign sysReset = pinResetQ | srcActive_q;

  // system reset clears registers
  // no buffer storage lives here, so buffer contents are untouched
  assign regRst = rst | sysReset;

  // ---------------------------------------------------------------
  // serial host interface, mode 0, sampled on ref_clk
  // ---------------------------------------------------------------

  // sck must stay below a quarter of ref_clk for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sckPrev_q <= 1'b0;
    end else begin
      sckPrev_q <= spiSck;
    end
  end

  assign sckRise  = spiSck & ~sckPrev_q & ~spiCsN;
  assign sckFall  = ~spiSck & sckPrev_q & ~spiCsN;
  assign byteIn   = {inShift_q[6:0], spiMosi};
  assign byteDone = sckRise && (bitCnt_q == 3'h7);

  // host interface state survives system reset so a command can finish
  always_ff @(posedge ref_clk) begin
    if (rst || spiCsN) begin
      phase_q  <= erc_pkg::PH_CMD;
      bitCnt_q <= 3'h0;
    end else if (sckRise) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      if (byteDone) begin
        case (phase_q)
          erc_pkg::PH_CMD: begin
            phase_q <= (byteIn[7:5] == erc_pkg::OP_SYSRST) ? erc_pkg::PH_DONE : erc_pkg::PH_DATA;
          end
          erc_pkg::PH_DATA: begin
            phase_q <= erc_pkg::PH_DONE;
          end
          erc_pkg::PH_DONE: begin
            phase_q <= erc_pkg::PH_DONE;
          end
          default: begin
            phase_q <= erc_pkg::PH_CMD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inShift_q <= 8'h00;
    end else if (sckRise) begin
      inShift_q <= byteIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opcode_q <= 3'h0;
      addr_q   <= 5'h00;
    end else if (byteDone && phase_q == erc_pkg::PH_CMD) begin
      opcode_q <= byteIn[7:5];
      addr_q   <= byteIn[4:0];
    end
  end

  // read data is loaded after the command byte, shifted on falling edges
  always_ff @(posedge ref_clk) begin
    if (rst || spiCsN) begin
      outShift_q <= 8'h00;
    end else if (byteDone && phase_q == erc_pkg::PH_CMD) begin
      outShift_q <= rdData;
    end else if (sckFall && phase_q == erc_pkg::PH_DATA && bitCnt_q != 3'h0) begin
      outShift_q <= {outShift_q[6:0], 1'b0};
    end
  end

  always_comb begin
    spiMiso   = outShift_q[7];
    spiMisoOe = ~spiCsN;
  end

  assign srcPulse = byteDone && phase_q == erc_pkg::PH_CMD && byteIn[7:5] == erc_pkg::OP_SYSRST;
  assign wrStrobe = byteDone && phase_q == erc_pkg::PH_DATA &&
                    (opcode_q == erc_pkg::OP_WRITE || opcode_q == erc_pkg::OP_BSET ||
                     opcode_q == erc_pkg::OP_BCLR);
  assign wrData   = byteIn;

  // ---------------------------------------------------------------
  // register read and write
  // ---------------------------------------------------------------

  function automatic logic [7:0] apply_op(input logic [2:0] op, input logic [7:0] old, input logic [7:0] val);
    logic [7:0] res;
    res = val;
    if (op == erc_pkg::OP_BSET) begin
      res = old | val;
    end else if (op == erc_pkg::OP_BCLR) begin
      res = old & ~val;
    end
    return res;
  endfunction : apply_op

  always_comb begin
    case (addr_q == 5'h00 ? byteIn[4:0] : byteIn[4:0])
      erc_pkg::ADDR_ETH_CTRL:    rdData = ethCtrl_q;
      erc_pkg::ADDR_PHY_CTRL_HI: rdData = phyCtrl_q[15:8];
      erc_pkg::ADDR_PHY_CTRL_LO: rdData = phyCtrl_q[7:0];
      default:                   rdData = 8'h00;
    endcase
  end

  assign ethNew = apply_op(opcode_q, ethCtrl_q, wrData);

  always_comb begin
    phyNew = phyCtrl_q;
    if (addr_q == erc_pkg::ADDR_PHY_CTRL_HI) begin
      phyNew[15:8] = apply_op(opcode_q, phyCtrl_q[15:8], wrData);
    end else if (addr_q == erc_pkg::ADDR_PHY_CTRL_LO) begin
      phyNew[7:0] = apply_op(opcode_q, phyCtrl_q[7:0], wrData);
    end
  end

  // ethernet_control_one
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      // both path resets follow system reset
      ethCtrl_q <= erc_pkg::ECTL_RESET;
    end else begin
      if (wrStrobe && addr_q == erc_pkg::ADDR_ETH_CTRL) begin
        ethCtrl_q <= ethNew;
        if (ethNew[erc_pkg::ECTL_TX_RST]) begin
          ethCtrl_q[erc_pkg::ECTL_TX_REQ] <= 1'b0;
        end
        if (ethNew[erc_pkg::ECTL_RX_RST]) begin
          ethCtrl_q[erc_pkg::ECTL_RX_EN] <= 1'b0;
        end
      end else begin
        // clear request on completion
        // a host write in the same cycle wins, so a new request is never lost
        if (txFrameDone || ethCtrl_q[erc_pkg::ECTL_TX_RST]) begin
          ethCtrl_q[erc_pkg::ECTL_TX_REQ] <= 1'b0;
        end
        if (ethCtrl_q[erc_pkg::ECTL_RX_RST]) begin
          ethCtrl_q[erc_pkg::ECTL_RX_EN] <= 1'b0;
        end
      end
    end
  end

  assign phyStart = wrStrobe && addr_q == erc_pkg::ADDR_PHY_CTRL_HI && phyNew[erc_pkg::PCTL_SOFT_RST];

  erc_phy_reset_timer u_phy_timer (
    .ref_clk (ref_clk),
    .rst     (regRst),
    .start   (phyStart),
    .busyQ   (phyBusy)
  );

  // phy_control_one
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      phyCtrl_q <= erc_pkg::PCTL_RESET;
    end else if (phyStart || phyBusy) begin
      // PHY registers to default
      // writes during the reset are dropped
      phyCtrl_q <= erc_pkg::PCTL_RESET;
      phyCtrl_q[erc_pkg::PCTL_SOFT_RST] <= 1'b1;
    end else if (phyCtrl_q[erc_pkg::PCTL_SOFT_RST]) begin
      phyCtrl_q <= erc_pkg::PCTL_RESET;
    end else if (wrStrobe) begin
      phyCtrl_q <= phyNew & erc_pkg::PCTL_STORE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  always_comb begin
    // reset pin is never driven
    // the pin has no output path; internal resets only fan out here
    resets.sys = sysReset;
    // held while the bit is set
    resets.tx  = sysReset | ethCtrl_q[erc_pkg::ECTL_TX_RST];
    // held while the bit is set
    resets.rx  = sysReset | ethCtrl_q[erc_pkg::ECTL_RX_RST];
    resets.phy = sysReset | phyBusy | phyCtrl_q[erc_pkg::PCTL_SOFT_RST];
  end

  assign rxEnable  = ethCtrl_q[erc_pkg::ECTL_RX_EN];
  assign txRequest = ethCtrl_q[erc_pkg::ECTL_TX_REQ];

  always_comb begin
    phyMode.loopback   = phyCtrl_q[erc_pkg::PCTL_LOOPBACK];
    phyMode.powerDown  = phyCtrl_q[erc_pkg::PCTL_POWER_DOWN];
    phyMode.fullDuplex = phyCtrl_q[erc_pkg::PCTL_DUPLEX];
  end
endmodule : erc_reset_control
`default_nettype wire

/* File: verification/erc_reset_control_sva.sv */
`default_nettype none
module erc_reset_control_chk (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // watched ports
  input wire logic                   resetPinN,
  input wire logic                   spiCsN,
  input wire logic                   txFrameDone,
  input wire logic                   txRequest,
  input wire logic                   rxEnable,
  input wire erc_pkg::erc_resets_s   resets,
  input wire erc_pkg::erc_phy_mode_s phyMode
);
  localparam int PhyMin = erc_pkg::PHY_RST_CYCLES - 2;
  localparam int PhyMax = erc_pkg::PHY_RST_CYCLES + 8;
  logic [3:0]  lowCntQ;
  logic [12:0] phyCntQ;

  // saturating so a long hold never wraps back under the filter width
  always_ff @(posedge ref_clk) begin
    if (rst || resetPinN) begin
      lowCntQ <= 4'h0;
    end else if (lowCntQ != 4'hf) begin
      lowCntQ <= lowCntQ + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !resets.phy) begin
      phyCntQ <= 13'h0;
    end else if (phyCntQ != 13'h1fff) begin
      phyCntQ <= phyCntQ + 13'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_sys_covers_paths: assert property (resets.sys |-> resets.tx && resets.rx)
    else $error("system reset without path resets");
  chk_tx_req_held: assert property ($past(resets.tx) && resets.tx |-> !txRequest)
    else $error("transmit request survives transmit reset");
  chk_rx_en_held: assert property ($past(resets.rx) && resets.rx |-> !rxEnable)
    else $error("receive enable survives receive reset");
  chk_pin_long_low: assert property (lowCntQ >= 4'hc |-> resets.sys)
    else $error("long low pin without system reset");
  chk_pin_filter: assert property ($rose(resets.sys) && spiCsN |-> lowCntQ >= 4'hb)
    else $error("short pin pulse caused a reset");
  chk_phy_min_hold: assert property ($fell(resets.phy) && !$past(resets.sys) |-> int'($past(phyCntQ)) >= PhyMin)
    else $error("phy reset ended early");
  chk_phy_self_clear: assert property (resets.phy && !resets.sys |-> int'(phyCntQ) <= PhyMax)
    else $error("phy reset never clears");
  chk_phy_mode_quiet: assert property ($past(resets.phy) && resets.phy |-> phyMode == 3'h0)
    else $error("phy mode active during phy reset");
  chk_done_clears_req: assert property (txFrameDone && txRequest && spiCsN |=> !txRequest)
    else $error("frame done did not clear request");
  chk_sys_restores: assert property ($fell(resets.sys) |-> !txRequest && !rxEnable && phyMode == 3'h0)
    else $error("registers not restored by system reset");
endmodule : erc_reset_control_chk

bind erc_reset_control erc_reset_control_chk chk_u (
  .ref_clk(ref_clk), .rst(rst), .resetPinN(resetPinN), .spiCsN(spiCsN), .txFrameDone(txFrameDone),
  .txRequest(txRequest), .rxEnable(rxEnable), .resets(resets), .phyMode(phyMode)
);
`default_nettype wire

/* File: verification/erc_host_model.sv */
`default_nettype none
module erc_host_model (
  // clock
  input  wire logic ref_clk,
  // serial host port
  output var logic  spiCsN,
  output var logic  spiSck,
  output var logic  spiMosi,
  input  wire logic spiMiso
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spiCsN = 1'b1;
    spiSck = 1'b0;
    spiMosi = 1'b0;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : waitClk

  // three cycles per sck level keeps clear of the two-cycle minimum
  task automatic xfer(input logic [15:0] frame, input int nBits, output logic [7:0] rdData);
    rdData = 8'h00;
    waitClk(1);
    spiCsN = 1'b0;
    waitClk(2);
    for (int i = 0; i < nBits; i++) begin
      spiMosi = frame[15 - i];
      waitClk(3);
      if (i >= 8) rdData = {rdData[6:0], spiMiso};
      spiSck = 1'b1;
      waitClk(3);
      spiSck = 1'b0;
    end
    waitClk(3);
    spiCsN = 1'b1;
    // released line shows the inverse so stale data cannot pass
    spiMosi = ~spiMosi;
    waitClk(3);
  endtask : xfer

  task automatic wr(input logic [4:0] addr, input logic [7:0] data);
    logic [7:0] d;
    logic [7:0] sent;
    sent = data;
    if (addr == erc_pkg::ADDR_PHY_CTRL_HI) sent[2] = 1'b0;
    if (addr == erc_pkg::ADDR_PHY_CTRL_LO) sent[7] = 1'b0;
    xfer({erc_pkg::OP_WRITE, addr, sent}, 16, d);
  endtask : wr

  task automatic rd(input logic [4:0] addr, output logic [7:0] data);
    xfer({erc_pkg::OP_READ, addr, 8'h00}, 16, data);
  endtask : rd

  task automatic sysReset;
    logic [7:0] d;
    xfer({erc_pkg::OP_SYSRST, 5'h1f, 8'h00}, 8, d);
  endtask : sysReset

  task automatic phyPoll(output logic done);
    logic [7:0] d;
    done = 1'b0;
    for (int i = 0; i < 60 && !done; i++) begin
      rd(erc_pkg::ADDR_PHY_CTRL_HI, d);
      done = !d[7];
    end
  endtask : phyPoll
endmodule : erc_host_model
`default_nettype wire

/* File: verification/test_ethernet_reset_control.sv */
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) begin \
      failCount++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_ethernet_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   ref_clk, rst, resetPinN, txFrameDone, txRequest, rxEnable;
  logic                   spiCsN, spiSck, spiMosi, spiMiso, spiMisoOe, seen, done;
  erc_pkg::erc_resets_s   resets;
  erc_pkg::erc_phy_mode_s phyMode;
  logic [7:0]             rdData;
  int                     failCount, checksDone, cycles, t0;

  erc_reset_control dut_u (
    .ref_clk(ref_clk), .rst(rst), .resetPinN(resetPinN), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .txFrameDone(txFrameDone),
    .txRequest(txRequest), .rxEnable(rxEnable), .resets(resets), .phyMode(phyMode)
  );
  erc_host_model host_u (
    .ref_clk(ref_clk), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cycles++;

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : printVerdict

  task automatic rdChk(input logic [4:0] addr, input logic [7:0] exp, input string what);
    host_u.rd(addr, rdData);
    `CHK(what, exp, rdData)
  endtask : rdChk

  task automatic testPowerOn;
    rdChk(erc_pkg::ADDR_ETH_CTRL, erc_pkg::ECTL_RESET, "ectl reset");
    rdChk(erc_pkg::ADDR_PHY_CTRL_HI, erc_pkg::PCTL_RESET[15:8], "pctl hi reset");
    rdChk(erc_pkg::ADDR_PHY_CTRL_LO, erc_pkg::PCTL_RESET[7:0], "pctl lo reset");
    `CHK("resets idle", 4'h0, resets)
    `CHK("miso oe idle", 1'b0, spiMisoOe)
  endtask : testPowerOn

  task automatic testTxControl;
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h08);
    `CHK("tx request set", 1'b1, txRequest)
    txFrameDone = 1'b1;
    step(1);
    txFrameDone = 1'b0;
    step(1);
    `CHK("tx request cleared", 1'b0, txRequest)
    host_u.xfer({erc_pkg::OP_BSET, erc_pkg::ADDR_ETH_CTRL, 8'h04}, 16, rdData);
    `CHK("bit set rx enable", 1'b1, rxEnable)
    host_u.xfer({erc_pkg::OP_BCLR, erc_pkg::ADDR_ETH_CTRL, 8'h04}, 16, rdData);
    `CHK("bit clear rx enable", 1'b0, rxEnable)
    host_u.wr(5'h05, 8'hff);
    rdChk(5'h05, 8'h00, "unmapped");
  endtask : testTxControl

  task automatic testPathResets;
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h0c);
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h8c);
    `CHK("tx only reset", 6'h11, {resets, txRequest, rxEnable})
    rdChk(erc_pkg::ADDR_ETH_CTRL, 8'h84, "ectl in tx reset");
    step(20);
    `CHK("tx reset held", 4'h4, resets)
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h04);
    `CHK("tx reset released", 5'h01, {resets, rxEnable})
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h44);
    `CHK("rx only reset", 5'h04, {resets, rxEnable})
    rdChk(erc_pkg::ADDR_ETH_CTRL, 8'h40, "ectl in rx reset");
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h00);
    `CHK("rx reset released", 4'h0, resets)
  endtask : testPathResets

  task automatic testPhyControl;
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_HI, 8'h40);
    `CHK("loopback", 3'h4, phyMode)
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_HI, 8'h08);
    `CHK("power down", 3'h2, phyMode)
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_HI, 8'h01);
    `CHK("full duplex", 3'h1, phyMode)
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_HI, 8'h7f);
    rdChk(erc_pkg::ADDR_PHY_CTRL_HI, 8'h49, "pctl hi bits");
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_LO, 8'hff);
    rdChk(erc_pkg::ADDR_PHY_CTRL_LO, 8'h00, "pctl lo bits");
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_HI, 8'hc9);
    t0 = cycles;
    `CHK("phy reset", 4'h8, {resets.phy, phyMode})
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_HI, 8'h00);
    host_u.rd(erc_pkg::ADDR_PHY_CTRL_HI, rdData);
    `CHK("phy reset bit held", 1'b1, rdData[7])
    host_u.phyPoll(done);
    `CHK("phy reset done", 1'b1, done)
    `CHK("phy reset time", 1'b1, (cycles - t0 >= erc_pkg::PHY_RST_CYCLES - 10) && (cycles - t0 <= erc_pkg::PHY_RST_CYCLES + 250))
    rdChk(erc_pkg::ADDR_PHY_CTRL_HI, 8'h00, "pctl after phy reset");
  endtask : testPhyControl

  task automatic testSysCmd;
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h0c);
    host_u.wr(erc_pkg::ADDR_PHY_CTRL_HI, 8'h49);
    host_u.sysReset();
    `CHK("command reset", 4'hf, resets)
    for (int i = 0; i < 100 && resets.sys !== 1'b0; i++) step(1);
    `CHK("after command reset", 5'h00, {txRequest, rxEnable, phyMode})
    step(1250);
    rdChk(erc_pkg::ADDR_ETH_CTRL, 8'h00, "ectl after command");
    rdChk(erc_pkg::ADDR_PHY_CTRL_HI, 8'h00, "pctl after command");
  endtask : testSysCmd

  task automatic pinPulse(input int n);
    seen = 1'b0;
    resetPinN = 1'b0;
    repeat (n) begin
      step(1);
      seen = seen | resets.sys;
    end
    resetPinN = 1'b1;
    repeat (4) begin
      step(1);
      seen = seen | resets.sys;
    end
  endtask : pinPulse

  task automatic testPin;
    host_u.wr(erc_pkg::ADDR_ETH_CTRL, 8'h04);
    pinPulse(10);
    `CHK("short pin pulse", 2'h1, {seen, rxEnable})
    pinPulse(12);
    `CHK("long pin pulse", 2'h2, {seen, rxEnable})
  endtask : testPin

  initial begin
    rst = 1'b1;
    resetPinN = 1'b1;
    txFrameDone = 1'b0;
    step(5);
    rst = 1'b0;
    step(4);
    testPowerOn();
    testTxControl();
    testPathResets();
    testPhyControl();
    testSysCmd();
    testPin();
    printVerdict();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    failCount++;
    $display("ERROR watchdog expected finish seen timeout");
    printVerdict();
  end
endmodule : test_ethernet_reset_control
`default_nettype wire
